// ==== rpe_pkg.sv ====
// rpe_pkg: constants, register map and types for the rtc pin event/output routing block
// assumes a single 100 MHz clock and an 8-bit internal register port
//
// What this block does
// R1 - external input edge, polarity selectable, sets event one when its enable is set
// R2 - software reads the present level of the external event input
// R3 - watchdog kick pin edge, polarity selectable, sets event two when enabled
// R4 - software reads the present level of the watchdog kick pin
// R5 - watchdog kick pin activity restarts the watchdog; host drives it
// R6 - reset passthrough: low external reset drives reset pin to its asserted level
// R7 - primary interrupt pin held low after power-up until registers are reachable
// R8 - host waits on primary interrupt pin before any serial access
// R9 - primary out select picks static level, not combined, square wave or not alarm
// R10 - square wave reaches the primary pin only while square wave enable is set
// R11 - primary interrupt pin is open drain: drives low only, releases for high
// R12 - serial select is active low; accesses ignored while it is high
// R13 - reset drive polarity clears to zero at power-up, giving active low reset
// R14 - each external event latches a sticky flag feeding combined interrupt
package rpe_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_NS = 200;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CW = 8;

  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 4;

  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h0F;
  localparam logic [7:0] ADDR_CONTROL1 = 8'h10;
  localparam logic [7:0] ADDR_CONTROL2 = 8'h11;
  localparam logic [7:0] ADDR_INT_MASK = 8'h12;
  localparam logic [7:0] ADDR_SQW = 8'h13;
  localparam logic [7:0] ADDR_EXT_CFG = 8'h14;

  // status fields
  localparam int ST_EXT1_FLAG = 0;
  localparam int ST_EXT2_FLAG = 1;
  localparam int ST_EXT_LEVEL = 2;
  localparam int ST_WDT_LEVEL = 3;
  // control1 fields
  localparam int C1_STATIC_LEVEL = 0;
  localparam int C1_RST_POL = 1;
  // control2 fields
  localparam int C2_OUT_SEL_LO = 0;
  localparam int C2_PASSTHRU = 5;
  // int mask fields
  localparam int IM_EXT1_EN = 0;
  localparam int IM_EXT2_EN = 1;
  // sqw fields
  localparam int SQW_EN = 7;
  localparam int SQW_CFG_W = 5;
  // ext cfg fields, 1 selects rising edge
  localparam int EC_EXT1_POL = 0;
  localparam int EC_EXT2_POL = 1;

  // synchroniser lanes
  localparam int SY_EXT = 0;
  localparam int SY_WDT = 1;
  localparam int SY_RST = 2;
  localparam int SY_SEL = 3;

  // reset values
  localparam logic STATIC_LEVEL_RST = 1'b1;
  localparam logic RST_POL_RST = 1'b0;
  localparam logic [1:0] OUT_SEL_RST = 2'h0;
  localparam logic [SQW_CFG_W-1:0] SQW_CFG_RST = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

  // primary output sources
  typedef enum logic [1:0] {
    OSEL_STATIC = 2'h0,
    OSEL_NOT_IRQ = 2'h1,
    OSEL_SQW = 2'h2,
    OSEL_NOT_ALARM = 2'h3
  } rpe_osel_type;

  // start-up state, one-hot
  typedef enum logic [1:0] {
    PWR_HOLD = 2'b01,
    PWR_READY = 2'b10
  } rpe_pwr_type;

endpackage

// ==== rpe_sync.sv ====
// rpe_sync: two-flop synchronisers for the asynchronous pins
// assumes the pins are slow levels with no relation to clk
`timescale 1ns/1ps
module rpe_sync
  import rpe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins and their reset level
  input wire logic [SYNC_W-1:0] pin_in,
  input wire logic [SYNC_W-1:0] rst_level,
  // synchronised levels
  output logic [SYNC_W-1:0] pin_sync
);

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;

  // first stage is read only by the second; reset levels are idle pin levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {SYNC_W{1'b1}};
      sync_r <= {SYNC_W{1'b1}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  // rst_level kept for a future per-lane idle choice; all lanes idle high
  assign pin_sync = sync_r | (rst_level & ~rst_level);

endmodule

// ==== rpe_top.sv ====
// rpe_top: pin-level routing of external events, reset passthrough and primary irq pin
// assumes an internal serial engine on clk presents a plain register port;
// alarm, other interrupt sources and square wave come from logic on clk
`timescale 1ns/1ps
module rpe_top
  import rpe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port from the serial engine
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // pins from the host
  input wire logic external_event_input,
  input wire logic watchdog_kick_input,
  input wire logic external_reset_in_n,
  input wire logic serial_select_n,
  // internal sources on clk
  input wire logic alarm_interrupt,
  input wire logic other_irq_in,
  input wire logic square_wave_in,
  // open-drain primary interrupt pin
  output logic primary_irq_pin_o,
  output logic primary_irq_pin_oe,
  // open-drain reset drive pin
  output logic reset_drive_pin_o,
  output logic reset_drive_pin_oe,
  // status towards neighbours
  output logic wdt_kick_pulse,
  output logic serial_active,
  output logic device_ready,
  output logic [SQW_CFG_W-1:0] square_wave_config
);

  // synchronised pins
  logic [SYNC_W-1:0] pin_sync;
  logic ext_lvl;
  logic wdt_lvl;
  logic extr_n_lvl;
  logic sel_n_lvl;
  logic ext_prev_r;
  logic wdt_prev_r;

  // registers
  logic ext1_flag_r;
  logic ext2_flag_r;
  logic static_level_r;
  logic rst_pol_r;
  logic [1:0] out_sel_r;
  logic passthru_r;
  logic ext1_en_r;
  logic ext2_en_r;
  logic sqw_en_r;
  logic [SQW_CFG_W-1:0] sqw_cfg_r;
  logic ext1_pol_r;
  logic ext2_pol_r;

  // start-up
  rpe_pwr_type pwr_r;
  rpe_pwr_type pwr_nxt;
  logic [STARTUP_CW-1:0] start_cnt_r;

  // decoded strobes and events
  logic acc_ok;
  logic wr_ok;
  logic rd_ok;
  logic ext1_evt;
  logic ext2_evt;
  logic combined_irq;
  logic prim_level_nxt;
  logic rst_level_nxt;
  logic rst_asserted;
  logic [DATA_W-1:0] rdata_nxt;

  // edge detect with selectable sense; pol high means rising edge
  function automatic logic edge_hit(input logic cur, input logic prev, input logic pol);
    edge_hit = pol ? (cur & ~prev) : (~cur & prev);
  endfunction

  // address match for a qualified write
  function automatic logic wr_hit(input logic ok, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] target);
    wr_hit = ok && (a == target);
  endfunction

  // every pin passes two flops before any logic reads it
  rpe_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in({serial_select_n, external_reset_in_n, watchdog_kick_input,
             external_event_input}),
    .rst_level({SYNC_W{1'b1}}),
    .pin_sync(pin_sync)
  );

  assign ext_lvl = pin_sync[SY_EXT];
  assign wdt_lvl = pin_sync[SY_WDT];
  assign extr_n_lvl = pin_sync[SY_RST];
  assign sel_n_lvl = pin_sync[SY_SEL];

  // access only while selected and out of start-up hold
  assign acc_ok = ~sel_n_lvl && (pwr_r == PWR_READY); // R12
  assign wr_ok = reg_wr && acc_ok;
  assign rd_ok = reg_rd && acc_ok;

  // previous synced levels for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev_r <= 1'b1;
      wdt_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= ext_lvl;
      wdt_prev_r <= wdt_lvl;
    end
  end

  // events only count while enabled
  assign ext1_evt = ext1_en_r && edge_hit(ext_lvl, ext_prev_r, ext1_pol_r); // R1
  assign ext2_evt = ext2_en_r && edge_hit(wdt_lvl, wdt_prev_r, ext2_pol_r); // R3

  // any change on the kick pin restarts the watchdog counter outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_kick_pulse <= 1'b0;
    end else begin
      wdt_kick_pulse <= wdt_lvl ^ wdt_prev_r; // R5
    end
  end

  // sticky flags: write zero clears, an event in the same cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext1_flag_r <= 1'b0;
      ext2_flag_r <= 1'b0;
    end else begin
      if (ext1_evt) begin
        ext1_flag_r <= 1'b1; // R14
      end else if (wr_hit(wr_ok, reg_addr, ADDR_STATUS) && !reg_wdata[ST_EXT1_FLAG]) begin
        ext1_flag_r <= 1'b0;
      end
      if (ext2_evt) begin
        ext2_flag_r <= 1'b1; // R14
      end else if (wr_hit(wr_ok, reg_addr, ADDR_STATUS) && !reg_wdata[ST_EXT2_FLAG]) begin
        ext2_flag_r <= 1'b0;
      end
    end
  end

  assign combined_irq = ext1_flag_r | ext2_flag_r | other_irq_in; // R14

  // control1: static level and reset polarity
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      static_level_r <= STATIC_LEVEL_RST;
      rst_pol_r <= RST_POL_RST; // R13
    end else if (wr_hit(wr_ok, reg_addr, ADDR_CONTROL1)) begin
      static_level_r <= reg_wdata[C1_STATIC_LEVEL];
      rst_pol_r <= reg_wdata[C1_RST_POL];
    end
  end

  // control2: output select and reset passthrough
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sel_r <= OUT_SEL_RST;
      passthru_r <= 1'b0;
    end else if (wr_hit(wr_ok, reg_addr, ADDR_CONTROL2)) begin
      out_sel_r <= reg_wdata[C2_OUT_SEL_LO +: 2]; // R9
      passthru_r <= reg_wdata[C2_PASSTHRU];
    end
  end

  // interrupt enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext1_en_r <= 1'b0;
      ext2_en_r <= 1'b0;
    end else if (wr_hit(wr_ok, reg_addr, ADDR_INT_MASK)) begin
      ext1_en_r <= reg_wdata[IM_EXT1_EN];
      ext2_en_r <= reg_wdata[IM_EXT2_EN];
    end
  end

  // square wave enable and configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sqw_en_r <= 1'b0;
      sqw_cfg_r <= SQW_CFG_RST;
    end else if (wr_hit(wr_ok, reg_addr, ADDR_SQW)) begin
      sqw_en_r <= reg_wdata[SQW_EN];
      sqw_cfg_r <= reg_wdata[SQW_CFG_W-1:0];
    end
  end

  // event polarities
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext1_pol_r <= 1'b0;
      ext2_pol_r <= 1'b0;
    end else if (wr_hit(wr_ok, reg_addr, ADDR_EXT_CFG)) begin
      ext1_pol_r <= reg_wdata[EC_EXT1_POL];
      ext2_pol_r <= reg_wdata[EC_EXT2_POL];
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = RDATA_UNMAPPED;
    if (reg_addr == ADDR_STATUS) begin
      rdata_nxt[ST_EXT1_FLAG] = ext1_flag_r;
      rdata_nxt[ST_EXT2_FLAG] = ext2_flag_r;
      rdata_nxt[ST_EXT_LEVEL] = ext_lvl; // R2
      rdata_nxt[ST_WDT_LEVEL] = wdt_lvl; // R4
    end else if (reg_addr == ADDR_CONTROL1) begin
      rdata_nxt[C1_STATIC_LEVEL] = static_level_r;
      rdata_nxt[C1_RST_POL] = rst_pol_r;
    end else if (reg_addr == ADDR_CONTROL2) begin
      rdata_nxt[C2_OUT_SEL_LO +: 2] = out_sel_r;
      rdata_nxt[C2_PASSTHRU] = passthru_r;
    end else if (reg_addr == ADDR_INT_MASK) begin
      rdata_nxt[IM_EXT1_EN] = ext1_en_r;
      rdata_nxt[IM_EXT2_EN] = ext2_en_r;
    end else if (reg_addr == ADDR_SQW) begin
      rdata_nxt[SQW_EN] = sqw_en_r;
      rdata_nxt[SQW_CFG_W-1:0] = sqw_cfg_r;
    end else if (reg_addr == ADDR_EXT_CFG) begin
      rdata_nxt[EC_EXT1_POL] = ext1_pol_r;
      rdata_nxt[EC_EXT2_POL] = ext2_pol_r;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= RDATA_UNMAPPED;
    end else if (rd_ok) begin
      reg_rdata <= rdata_nxt; // R12
    end else begin
      reg_rdata <= RDATA_UNMAPPED;
    end
  end

  // start-up hold: counts a fixed settle time before the port opens
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_HOLD: begin
        if (start_cnt_r == STARTUP_CW'(STARTUP_CYCLES - 1)) begin
          pwr_nxt = PWR_READY;
        end
      end
      PWR_READY: begin
        pwr_nxt = PWR_READY;
      end
      default: begin
        pwr_nxt = PWR_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r <= PWR_HOLD;
      start_cnt_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r == PWR_HOLD) begin
        start_cnt_r <= start_cnt_r + STARTUP_CW'(1);
      end
    end
  end

  // primary pin source; disabled square wave releases the pin
  always_comb begin
    case (rpe_osel_type'(out_sel_r))
      OSEL_STATIC: prim_level_nxt = static_level_r;
      OSEL_NOT_IRQ: prim_level_nxt = ~combined_irq;
      OSEL_SQW: prim_level_nxt = sqw_en_r ? square_wave_in : 1'b1; // R10
      OSEL_NOT_ALARM: prim_level_nxt = ~alarm_interrupt;
      default: prim_level_nxt = 1'b1;
    endcase
    if (pwr_r != PWR_READY) begin
      prim_level_nxt = 1'b0; // R7
    end
  end

  // open drain: only ever pulls low, enable follows the low level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_irq_pin_o <= 1'b0;
      primary_irq_pin_oe <= 1'b1; // R7
    end else begin
      primary_irq_pin_o <= 1'b0;
      primary_irq_pin_oe <= ~prim_level_nxt; // R11
    end
  end

  // reset passthrough, asserted level set by polarity
  assign rst_asserted = passthru_r && !extr_n_lvl; // R6
  assign rst_level_nxt = rst_asserted ? rst_pol_r : ~rst_pol_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_drive_pin_o <= 1'b0;
      reset_drive_pin_oe <= 1'b0;
    end else begin
      reset_drive_pin_o <= 1'b0;
      reset_drive_pin_oe <= ~rst_level_nxt; // R6
    end
  end

  // status outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_active <= 1'b0;
      device_ready <= 1'b0;
      square_wave_config <= SQW_CFG_RST;
    end else begin
      serial_active <= acc_ok;
      device_ready <= (pwr_nxt == PWR_READY);
      square_wave_config <= sqw_cfg_r;
    end
  end

  // checks
  chk_ext1_flag_set: assert property (@(posedge clk) disable iff (!arst_n) // R1
    ext1_evt |=> ext1_flag_r)
    else $error("event one did not set its flag");

  chk_ext_enable_gate: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (!ext2_en_r && !ext2_flag_r) |=> !ext2_flag_r)
    else $error("event two flag set while disabled");

  chk_flag_hold: assert property (@(posedge clk) disable iff (!arst_n) // R14
    (ext2_flag_r && !wr_ok) |=> ext2_flag_r)
    else $error("event two flag dropped without a write");

  chk_level_readback: assert property (@(posedge clk) disable iff (!arst_n) // R2
    (rd_ok && reg_addr == ADDR_STATUS) |=> reg_rdata[ST_EXT_LEVEL] == $past(ext_lvl))
    else $error("external level readback wrong");

  chk_wdt_kick: assert property (@(posedge clk) disable iff (!arst_n) // R5
    (wdt_lvl != wdt_prev_r) |=> wdt_kick_pulse ##1 !wdt_kick_pulse)
    else $error("watchdog kick pulse missing");

  chk_rst_passthru: assert property (@(posedge clk) disable iff (!arst_n) // R6
    rst_asserted |=> reset_drive_pin_oe == !$past(rst_pol_r))
    else $error("reset passthrough level wrong");

  chk_startup_hold: assert property (@(posedge clk) disable iff (!arst_n) // R7
    (pwr_r == PWR_HOLD) |=> primary_irq_pin_oe)
    else $error("primary pin released during start-up");

  chk_alarm_route: assert property (@(posedge clk) disable iff (!arst_n) // R9
    (pwr_r == PWR_READY && out_sel_r == OSEL_NOT_ALARM)
      |=> primary_irq_pin_oe == $past(alarm_interrupt))
    else $error("alarm not routed to primary pin");

  chk_sqw_gate: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (pwr_r == PWR_READY && out_sel_r == OSEL_SQW && !sqw_en_r) |=> !primary_irq_pin_oe)
    else $error("square wave driven while disabled");

  chk_deselect_ignore: assert property (@(posedge clk) disable iff (!arst_n) // R12
    (sel_n_lvl && reg_wr) |=> $stable(out_sel_r) && $stable(passthru_r))
    else $error("write taken while deselected");

endmodule

// ==== rpe_host_model.sv ====
// rpe_host_model: host side of the pin block, drives the pins and resolves open-drain lines
// assumes the bench requests pin levels; pull-ups sit on both open-drain lines
`timescale 1ns/1ps
module rpe_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin requests from the bench
  input wire logic ev_req,
  input wire logic kick_req,
  input wire logic rst_req_n,
  input wire logic sel_req_n,
  // pins towards the device
  output logic external_event_input,
  output logic watchdog_kick_input,
  output logic external_reset_in_n,
  output logic serial_select_n,
  // open-drain pins from the device
  input wire logic primary_irq_pin_o,
  input wire logic primary_irq_pin_oe,
  input wire logic reset_drive_pin_o,
  input wire logic reset_drive_pin_oe,
  // resolved line levels
  output logic irq_line,
  output logic rst_line
);
  logic ready_seen_r;

  // pull-ups give the high level whenever the device lets go
  assign irq_line = primary_irq_pin_oe ? primary_irq_pin_o : 1'b1;
  assign rst_line = reset_drive_pin_oe ? reset_drive_pin_o : 1'b1;

  // host holds off selecting until the irq line is released after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_seen_r <= 1'b0;
    end else if (irq_line) begin
      ready_seen_r <= 1'b1;
    end
  end

  // select stays high (idle) until the device is known to be reachable
  assign serial_select_n = sel_req_n | ~ready_seen_r;
  assign watchdog_kick_input = kick_req;
  assign external_event_input = ev_req;
  assign external_reset_in_n = rst_req_n;
endmodule

// ==== rpe_top_bench.sv ====
// rpe_top_bench: self-checking bench for rpe_top with the host model on the pins
// assumes the register port gives read data in the cycle after the strobe
`timescale 1ns/1ps
module rpe_top_bench
  import rpe_pkg::*;
;
  logic clk, arst_n, wr_s, rd_s, alarm, other, sqw_in, ev, kick, xrst, sel;
  logic [7:0] addr, wdata, rdata, kk, kick_cnt;
  logic ext_i, kick_i, xrst_i, sel_i, irq_o, irq_oe, rst_o, rst_oe, irq_line, rst_line;
  logic pulse, ser_act, dev_rdy;
  logic [SQW_CFG_W-1:0] sqw_cfg;
  int err_total, check_count, i;

  rpe_top DUT (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .external_event_input(ext_i),
    .watchdog_kick_input(kick_i), .external_reset_in_n(xrst_i), .serial_select_n(sel_i),
    .alarm_interrupt(alarm), .other_irq_in(other), .square_wave_in(sqw_in),
    .primary_irq_pin_o(irq_o), .primary_irq_pin_oe(irq_oe), .reset_drive_pin_o(rst_o),
    .reset_drive_pin_oe(rst_oe), .wdt_kick_pulse(pulse), .serial_active(ser_act),
    .device_ready(dev_rdy), .square_wave_config(sqw_cfg));

  rpe_host_model host (.clk(clk), .arst_n(arst_n), .ev_req(ev), .kick_req(kick),
    .rst_req_n(xrst), .sel_req_n(sel), .external_event_input(ext_i),
    .watchdog_kick_input(kick_i), .external_reset_in_n(xrst_i), .serial_select_n(sel_i),
    .primary_irq_pin_o(irq_o), .primary_irq_pin_oe(irq_oe), .reset_drive_pin_o(rst_o),
    .reset_drive_pin_oe(rst_oe), .irq_line(irq_line), .rst_line(rst_line));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count kick pulses so each pin change can be matched to exactly one pulse
  always @(posedge clk) begin
    if (!arst_n) begin
      kick_cnt <= 8'h00;
    end else if (pulse === 1'b1) begin
      kick_cnt <= kick_cnt + 8'h01;
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cb(input string nm, input logic seen, input logic exp);
    chk(nm, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // read data is taken mid-cycle after the strobe edge, the only cycle it stands
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(nm, rdata, exp);
  endtask

  // pins pass two synchroniser flops and an edge stage, so allow a margin
  task automatic st;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pins(input logic e, input logic k, input logic r);
    @(posedge clk);
    ev <= e;
    kick <= k;
    xrst <= r;
    st();
  endtask

  task automatic results;
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end

  // main sequence
  initial begin
    arst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr_s = 1'b0; rd_s = 1'b0;
    alarm = 1'b0; other = 1'b0; sqw_in = 1'b0; ev = 1'b0; kick = 1'b0; xrst = 1'b1;
    sel = 1'b0; err_total = 0; check_count = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cb("irq_oe_rst", irq_oe, 1'b1);
    cb("rst_oe_rst", rst_oe, 1'b0);
    @(posedge clk) arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    cb("irq_hold", irq_line, 1'b0);
    cb("rdy_hold", dev_rdy, 1'b0);
    for (i = 0; i < 40 && dev_rdy !== 1'b1; i++) @(posedge clk);
    if (dev_rdy !== 1'b1) begin
      err_total++;
      results();
    end
    st();
    st();
    cb("irq_free", irq_oe, 1'b0);
    cb("ser_on", ser_act, 1'b1);
    rdc("ctrl1_rst", ADDR_CONTROL1, 8'h01);
    @(negedge clk);
    chk("rdata_gone", rdata, 8'h00);
    rdc("ctrl2_rst", ADDR_CONTROL2, 8'h00);
    rdc("unmapped", 8'h20, 8'h00);
    rdc("stat_idle", ADDR_STATUS, 8'h00);
    // deselected: accesses must be dropped
    @(posedge clk) sel <= 1'b1;
    st();
    cb("ser_off", ser_act, 1'b0);
    wr(ADDR_INT_MASK, 8'h03);
    rdc("rd_desel", ADDR_INT_MASK, 8'h00);
    @(posedge clk) sel <= 1'b0;
    st();
    rdc("wr_desel", ADDR_INT_MASK, 8'h00);
    // pin levels and kick pulses
    kk = kick_cnt;
    pins(1'b1, 1'b1, 1'b1);
    rdc("lvl_high", ADDR_STATUS, 8'h0C);
    chk("kick_rise", kick_cnt, kk + 8'h01);
    pins(1'b0, 1'b0, 1'b1);
    rdc("lvl_low", ADDR_STATUS, 8'h00);
    chk("kick_fall", kick_cnt, kk + 8'h02);
    // ext1 on rising, ext2 on falling
    wr(ADDR_EXT_CFG, 8'h01);
    wr(ADDR_INT_MASK, 8'h03);
    pins(1'b1, 1'b1, 1'b1);
    rdc("ev_rise", ADDR_STATUS, 8'h0D);
    pins(1'b0, 1'b0, 1'b1);
    rdc("ev_fall", ADDR_STATUS, 8'h03);
    wr(ADDR_STATUS, 8'h02);
    rdc("clr_ext1", ADDR_STATUS, 8'h02);
    wr(ADDR_STATUS, 8'h00);
    rdc("clr_all", ADDR_STATUS, 8'h00);
    wr(ADDR_INT_MASK, 8'h00);
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    rdc("masked", ADDR_STATUS, 8'h00);
    // ext1 on falling, ext2 on rising
    wr(ADDR_EXT_CFG, 8'h02);
    wr(ADDR_INT_MASK, 8'h03);
    pins(1'b1, 1'b1, 1'b1);
    rdc("ev2_rise", ADDR_STATUS, 8'h0E);
    pins(1'b0, 1'b0, 1'b1);
    rdc("ev1_fall", ADDR_STATUS, 8'h03);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_INT_MASK, 8'h00);
    wr(ADDR_EXT_CFG, 8'h01);
    // primary output sources
    wr(ADDR_CONTROL1, 8'h00);
    st();
    cb("static_lo", irq_oe, 1'b1);
    wr(ADDR_CONTROL1, 8'h01);
    st();
    cb("static_hi", irq_line, 1'b1);
    wr(ADDR_CONTROL2, 8'h01);
    st();
    cb("comb_idle", irq_oe, 1'b0);
    @(posedge clk) other <= 1'b1;
    st();
    cb("comb_other", irq_oe, 1'b1);
    @(posedge clk) other <= 1'b0;
    wr(ADDR_INT_MASK, 8'h01);
    pins(1'b1, 1'b0, 1'b1);
    cb("comb_flag", irq_oe, 1'b1);
    wr(ADDR_STATUS, 8'h00);
    st();
    cb("comb_clr", irq_oe, 1'b0);
    wr(ADDR_CONTROL2, 8'h02);
    st();
    cb("sqw_off", irq_oe, 1'b0);
    wr(ADDR_SQW, 8'h9F);
    st();
    cb("sqw_lo", irq_oe, 1'b1);
    chk("sqw_cfg", {3'h0, sqw_cfg}, 8'h1F);
    @(posedge clk) sqw_in <= 1'b1;
    st();
    cb("sqw_hi", irq_oe, 1'b0);
    wr(ADDR_CONTROL2, 8'h03);
    @(posedge clk) alarm <= 1'b1;
    st();
    cb("alarm_on", irq_oe, 1'b1);
    @(posedge clk) alarm <= 1'b0;
    st();
    cb("alarm_off", irq_oe, 1'b0);
    cb("irq_o_low", irq_o, 1'b0);
    // reset passthrough in both polarities, then disabled
    wr(ADDR_CONTROL2, 8'h20);
    pins(1'b0, 1'b0, 1'b0);
    cb("pass_p0", rst_line, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    cb("idle_p0", rst_oe, 1'b0);
    wr(ADDR_CONTROL1, 8'h03);
    pins(1'b0, 1'b0, 1'b0);
    cb("pass_p1", rst_oe, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    cb("idle_p1", rst_oe, 1'b1);
    wr(ADDR_CONTROL1, 8'h01);
    wr(ADDR_CONTROL2, 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    cb("pass_off", rst_oe, 1'b0);
    results();
  end
endmodule
